// File: src/split_timer_pkg.sv
// Constants, register map and bus carrier for the split-mode dual byte timer
package split_timer_pkg;

  // Register offsets
  localparam logic [5:0] CTRLA_OFS      = 6'h00;
  localparam logic [5:0] SPLIT_CTRL_OFS = 6'h03;
  localparam logic [5:0] CMD_CLR_OFS    = 6'h04;
  localparam logic [5:0] CMD_SET_OFS    = 6'h05;
  localparam logic [5:0] IRQ_EN_OFS     = 6'h0a;
  localparam logic [5:0] IRQ_FLAG_OFS   = 6'h0b;
  localparam logic [5:0] DBG_OFS        = 6'h0e;
  localparam logic [5:0] LOW_CNT_OFS    = 6'h20;
  localparam logic [5:0] HIGH_CNT_OFS   = 6'h21;
  localparam logic [5:0] LOW_PER_OFS    = 6'h26;
  localparam logic [5:0] HIGH_PER_OFS   = 6'h27;
  localparam logic [5:0] LCMP_BASE_OFS  = 6'h28;
  localparam logic [5:0] CMP_STRIDE     = 6'h02;

  // Field positions
  localparam int ENABLE_BIT    = 0;
  localparam int CLKSEL_LSB    = 1;
  localparam int SPLIT_BIT     = 0;
  localparam int CMD_LSB       = 2;
  localparam int TGT_LSB        = 0;
  localparam int LCMP_FLAG_LSB  = 4;
  localparam int LOW_UNF_BIT    = 0;
  localparam int HIGH_UNF_BIT   = 1;
  localparam int RUN_HALTED_BIT = 0;

  // Implemented bits of the enable and flag registers
  localparam logic [7:0] IRQ_MASK = 8'h73;

  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] PER_RST = 8'hff;
  localparam logic [7:0] CMP_RST = 8'h00;

  // Command and command-target codes
  localparam logic [1:0] CMD_NONE       = 2'h0;
  localparam logic [1:0] CMD_RESTART    = 2'h2;
  localparam logic [1:0] CMD_HARD_RESET = 2'h3;
  localparam logic [1:0] TGT_BOTH       = 2'h3;

  // Prescaler masks: divide by 1,2,4,8,16,64,256,1024
  localparam logic [7:0][9:0] PRESC_MASK = {10'h3ff, 10'h0ff, 10'h03f, 10'h00f,
                                            10'h007, 10'h003, 10'h001, 10'h000};

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage

// File: src/split_mode_dual_byte_timer.sv
// Split-mode dual 8-bit down-counter timer with compare channels and command registers
`timescale 1ns/1ns
`default_nettype none

module split_mode_dual_byte_timer
  import split_timer_pkg::*;
#(
  parameter int NUM_CMP = 3
) (
  input  wire logic     i_mclk,
  input  wire logic     i_rstn,
  input  wire logic     i_ce,
  input  wire reg_req_s i_req,
  input  wire logic     i_debug_halt,
  output var  logic [7:0] o_rdata,
  output var  logic     o_irq,
  output var  logic     o_running
);

  if (NUM_CMP < 1 || NUM_CMP > 3) begin : g_num_cmp_check
    $error("NUM_CMP must lie between 1 and 3");
  end

  function automatic logic wr_hit(input reg_req_s r, input logic [5:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  logic             halt_meta;
  logic             halt_sync;
  logic [3:0]       ctrla_reg;
  logic             split_reg;
  logic [1:0]       target_reg;
  logic [7:0]       irq_en_reg;
  logic [7:0]       flags_reg;
  logic             run_halted_reg;
  logic [9:0]       div_reg;
  logic [7:0]       cnt_reg [2];
  logic [7:0]       per_reg [2];
  logic [7:0]       lcmp_reg [NUM_CMP];

  logic             enabled;
  logic             run;
  logic             tick;
  logic             set_wr;
  logic             clr_wr;
  logic [1:0]       cmd_code;
  logic [1:0]       target_after;
  logic             restart_cmd;
  logic             hard_cmd;
  logic [7:0]       flag_set;
  logic [7:0]       flag_clr;
  logic [9:0]       presc_mask;

  // Debug halt comes from another block's timing; sync before use
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      halt_meta <= 1'b0;
      halt_sync <= 1'b0;
    end else if (i_ce) begin
      halt_meta <= i_debug_halt;
      halt_sync <= halt_meta;
    end
  end

  assign enabled    = ctrla_reg[ENABLE_BIT];
  // Timer only runs in split mode; normal 16-bit mode is not built here
  assign run        = enabled && split_reg && (!halt_sync || run_halted_reg);
  assign presc_mask = PRESC_MASK[ctrla_reg[CLKSEL_LSB +: 3]];
  assign tick       = i_ce && run && ((div_reg & presc_mask) == presc_mask);

  // Split-only registers are decoded only while the split map is active
  assign set_wr      = wr_hit(i_req, CMD_SET_OFS) && split_reg;
  assign clr_wr      = wr_hit(i_req, CMD_CLR_OFS) && split_reg;
  assign cmd_code    = i_req.wdata[CMD_LSB +: 2];
  assign target_after = target_reg | i_req.wdata[TGT_LSB +: 2];
  // Reserved command and target codes do nothing
  assign restart_cmd = set_wr && (cmd_code == CMD_RESTART) && (target_after == TGT_BOTH);
  assign hard_cmd    = set_wr && (cmd_code == CMD_HARD_RESET) && (target_after == TGT_BOTH)
                       && !enabled;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_reg <= 10'h000;
    end else if (i_ce) begin
      if (!run || restart_cmd) begin
        div_reg <= 10'h000;
      end else begin
        div_reg <= div_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrla_reg  <= REG_RST[3:0];
      split_reg  <= 1'b0;
      run_halted_reg <= 1'b0;
      irq_en_reg <= REG_RST;
    end else if (i_ce) begin
      if (wr_hit(i_req, CTRLA_OFS)) begin
        ctrla_reg <= i_req.wdata[3:0];
      end
      if (wr_hit(i_req, SPLIT_CTRL_OFS)) begin
        split_reg <= i_req.wdata[SPLIT_BIT];
      end
      if (wr_hit(i_req, DBG_OFS)) begin
        run_halted_reg <= i_req.wdata[RUN_HALTED_BIT];
      end
      if (wr_hit(i_req, IRQ_EN_OFS) && split_reg) begin
        irq_en_reg <= i_req.wdata & IRQ_MASK;
      end
    end
  end

  // Only the target field is stored; the command field acts and is dropped
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      target_reg <= REG_RST[1:0];
    end else if (i_ce) begin
      if (set_wr) begin
        target_reg <= target_after;
      end else if (clr_wr) begin
        target_reg <= target_reg & ~i_req.wdata[TGT_LSB +: 2];
      end
    end
  end

  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_byte
      localparam logic [5:0] CNT_OFS = (b == 0) ? LOW_CNT_OFS : HIGH_CNT_OFS;
      localparam logic [5:0] PER_OFS = (b == 0) ? LOW_PER_OFS : HIGH_PER_OFS;

      always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
          cnt_reg[b] <= CNT_RST;
        end else if (i_ce) begin
          if (wr_hit(i_req, CNT_OFS) && split_reg) begin
            cnt_reg[b] <= i_req.wdata;
          end else if (hard_cmd || restart_cmd) begin
            cnt_reg[b] <= CNT_RST;
          end else if (tick) begin
            if (cnt_reg[b] == 8'h00) begin
              cnt_reg[b] <= per_reg[b];
            end else begin
              cnt_reg[b] <= cnt_reg[b] - 8'h01;
            end
          end
        end
      end

      always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
          per_reg[b] <= PER_RST;
        end else if (i_ce) begin
          if (wr_hit(i_req, PER_OFS) && split_reg) begin
            per_reg[b] <= i_req.wdata;
          end else if (hard_cmd) begin
            per_reg[b] <= PER_RST;
          end
        end
      end
    end
  endgenerate

  genvar n;
  generate
    for (n = 0; n < NUM_CMP; n++) begin : g_cmp
      localparam logic [5:0] OFS = LCMP_BASE_OFS + CMP_STRIDE * 6'(n);

      always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
          lcmp_reg[n] <= CMP_RST;
        end else if (i_ce) begin
          if (wr_hit(i_req, OFS) && split_reg) begin
            lcmp_reg[n] <= i_req.wdata;
          end else if (hard_cmd) begin
            lcmp_reg[n] <= CMP_RST;
          end
        end
      end
    end
  endgenerate

  // Events are sampled on the prescaled tick, so a halted timer raises none
  always_comb begin
    flag_set           = 8'h00;
    flag_set[LOW_UNF_BIT]  = tick && (cnt_reg[0] == 8'h00);
    flag_set[HIGH_UNF_BIT] = tick && (cnt_reg[1] == 8'h00);
    for (int k = 0; k < NUM_CMP; k++) begin
      flag_set[LCMP_FLAG_LSB + k] = tick && (cnt_reg[0] == lcmp_reg[k]);
    end
  end

  assign flag_clr = (wr_hit(i_req, IRQ_FLAG_OFS) && split_reg) ? (i_req.wdata & IRQ_MASK)
                                                               : 8'h00;

  // A new event in the clearing cycle wins so no event is lost
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      flags_reg <= REG_RST;
    end else if (i_ce) begin
      flags_reg <= (flags_reg & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq     <= 1'b0;
      o_running <= 1'b0;
    end else if (i_ce) begin
      o_irq     <= |(flags_reg & irq_en_reg);
      o_running <= run;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else if (i_ce && i_req.rd) begin
      o_rdata <= 8'h00;
      case (i_req.addr)
        CTRLA_OFS:      o_rdata <= {4'h0, ctrla_reg};
        SPLIT_CTRL_OFS: o_rdata <= {7'h00, split_reg};
        DBG_OFS:        o_rdata <= {7'h00, run_halted_reg};
        default: begin
          if (split_reg) begin
            case (i_req.addr)
              CMD_CLR_OFS,
              CMD_SET_OFS:  o_rdata <= {6'h00, target_reg};
              IRQ_EN_OFS:   o_rdata <= irq_en_reg;
              IRQ_FLAG_OFS: o_rdata <= flags_reg;
              LOW_CNT_OFS:  o_rdata <= cnt_reg[0];
              HIGH_CNT_OFS: o_rdata <= cnt_reg[1];
              LOW_PER_OFS:  o_rdata <= per_reg[0];
              HIGH_PER_OFS: o_rdata <= per_reg[1];
              default: begin
                for (int k = 0; k < NUM_CMP; k++) begin
                  if (i_req.addr == LCMP_BASE_OFS + CMP_STRIDE * 6'(k)) begin
                    o_rdata <= lcmp_reg[k];
                  end
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  logic cnt_untouched;
  assign cnt_untouched = !(wr_hit(i_req, LOW_CNT_OFS) && split_reg) && !restart_cmd && !hard_cmd;

  property p_cmd_reads_zero;
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && i_req.rd && (i_req.addr == CMD_SET_OFS || i_req.addr == CMD_CLR_OFS))
      |=> (o_rdata[CMD_LSB +: 2] == 2'h0);
  endproperty
  a_cmd_reads_zero: assert property (p_cmd_reads_zero)
    else $error("command field read back nonzero");

  property p_set_target;
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && set_wr) |=> (target_reg == $past(target_reg | i_req.wdata[1:0]));
  endproperty
  a_set_target: assert property (p_set_target)
    else $error("set register did not set target bits");

  property p_clr_target;
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && clr_wr) |=> (target_reg == $past(target_reg & ~i_req.wdata[1:0]));
  endproperty
  a_clr_target: assert property (p_clr_target)
    else $error("clear register did not clear target bits");

  property p_low_underflow;
    @(posedge i_mclk) disable iff (!i_rstn)
    (tick && cnt_reg[0] == 8'h00) |=> flags_reg[LOW_UNF_BIT];
  endproperty
  a_low_underflow: assert property (p_low_underflow)
    else $error("low underflow flag not set at bottom");

  property p_high_underflow;
    @(posedge i_mclk) disable iff (!i_rstn)
    (tick && cnt_reg[1] == 8'h00) |=> flags_reg[HIGH_UNF_BIT];
  endproperty
  a_high_underflow: assert property (p_high_underflow)
    else $error("high underflow flag not set at bottom");

  property p_cmp0_flag;
    @(posedge i_mclk) disable iff (!i_rstn)
    (tick && cnt_reg[0] == lcmp_reg[0]) |=> flags_reg[LCMP_FLAG_LSB];
  endproperty
  a_cmp0_flag: assert property (p_cmp0_flag)
    else $error("compare flag 0 not set on match");

  property p_flag_sticky;
    @(posedge i_mclk) disable iff (!i_rstn)
    (flags_reg[LOW_UNF_BIT] && !flag_clr[LOW_UNF_BIT]) |=> flags_reg[LOW_UNF_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("low underflow flag dropped without clear");

  property p_write_wins;
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && wr_hit(i_req, LOW_CNT_OFS) && split_reg) |=> (cnt_reg[0] == $past(i_req.wdata));
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("counter write lost");

  property p_reload;
    @(posedge i_mclk) disable iff (!i_rstn)
    (tick && cnt_reg[0] == 8'h00 && cnt_untouched) |=> (cnt_reg[0] == $past(per_reg[0]));
  endproperty
  a_reload: assert property (p_reload)
    else $error("low counter did not reload period");

  property p_hard_ignored;
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && enabled && set_wr && cmd_code == CMD_HARD_RESET) |=> (per_reg[0] == $past(per_reg[0])
      || $past(wr_hit(i_req, LOW_PER_OFS)));
  endproperty
  a_hard_ignored: assert property (p_hard_ignored)
    else $error("hard reset acted while enabled");

  property p_halt_freeze;
    @(posedge i_mclk) disable iff (!i_rstn)
    (halt_sync && !run_halted_reg && cnt_untouched) |=> (cnt_reg[0] == $past(cnt_reg[0]));
  endproperty
  a_halt_freeze: assert property (p_halt_freeze)
    else $error("counter moved during debug halt");

endmodule

`default_nettype wire

// File: dv/split_mode_dual_byte_timer_tb.sv
// Self-checking bench for the split-mode dual byte timer
`timescale 1ns/1ns
`default_nettype none

module split_mode_dual_byte_timer_tb
  import split_timer_pkg::*;
;
  logic       i_mclk;
  logic       i_rstn;
  logic       i_ce;
  reg_req_s   req;
  logic       halt;
  logic [7:0] rdata;
  logic       irq;
  logic       running;
  int         n_errors;
  int         n_compared;
  int         cycles;
  logic [7:0] d0, d1, lp, hp, c0, c1, en, m, v;

  split_mode_dual_byte_timer split_mode_dual_byte_timer_inst (
    .i_mclk       (i_mclk),
    .i_rstn       (i_rstn),
    .i_ce         (i_ce),
    .i_req        (req),
    .i_debug_halt (halt),
    .o_rdata      (rdata),
    .o_irq        (irq),
    .o_running    (running)
  );

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic summarize();
    if (n_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Long enough for four random rounds of about 160 cycles each
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      n_errors++;
    end
  endtask

  task automatic op(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    req <= '{w, r, a, d};
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
    op(1'b0, 1'b0, 6'h00, 8'h00);
  endtask

  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    op(1'b0, 1'b1, a, 8'h00);
    op(1'b0, 1'b0, 6'h00, 8'h00);
    #1;
    chk(rdata, exp);
  endtask

  // Two reads on consecutive edges see the count one clock cycle apart
  task automatic rd2(input logic [5:0] a);
    op(1'b0, 1'b1, a, 8'h00);
    op(1'b0, 1'b1, a, 8'h00);
    #1;
    d0 = rdata;
    op(1'b0, 1'b0, 6'h00, 8'h00);
    #1;
    d1 = rdata;
  endtask

  function automatic logic [7:0] nxt(input logic [7:0] c, input logic [7:0] p);
    return (c == 8'h00) ? p : c - 8'h01;
  endfunction

  initial begin
    n_errors = 0;
    n_compared = 0;
    cycles = 0;
    i_rstn = 1'b0;
    i_ce = 1'b1;
    req = '0;
    halt = 1'b0;
    void'($urandom(32'h1a53));
    repeat (10) @(posedge i_mclk);
    i_rstn <= 1'b1;
    rchk(SPLIT_CTRL_OFS, 8'h00);
    wr(LOW_PER_OFS, 8'h12);
    rchk(LOW_PER_OFS, 8'h00);
    wr(SPLIT_CTRL_OFS, 8'h01);
    rchk(SPLIT_CTRL_OFS, 8'h01);
    rchk(LOW_PER_OFS, 8'hff);
    rchk(HIGH_PER_OFS, 8'hff);
    rchk(CMD_CLR_OFS, 8'h00);
    rchk(CMD_SET_OFS, 8'h00);
    rchk(IRQ_EN_OFS, 8'h00);
    rchk(IRQ_FLAG_OFS, 8'h00);
    rchk(DBG_OFS, 8'h00);
    rchk(LOW_CNT_OFS, 8'h00);
    rchk(HIGH_CNT_OFS, 8'h00);
    wr(6'h10, 8'h5a);
    rchk(6'h10, 8'h00);
    repeat (4) begin
      lp = 8'($urandom_range(3, 40));
      hp = 8'($urandom_range(3, 40));
      c0 = 8'($urandom_range(0, lp));
      c1 = 8'($urandom_range(0, lp));
      en = 8'($urandom);
      m = 8'($urandom);
      v = 8'($urandom);
      wr(CTRLA_OFS, 8'h00);
      wr(LOW_PER_OFS, lp);
      wr(HIGH_PER_OFS, hp);
      wr(LCMP_BASE_OFS, c0);
      wr(6'h2a, c1);
      wr(6'h2c, lp + 8'h01);
      wr(LOW_CNT_OFS, 8'h00);
      wr(HIGH_CNT_OFS, 8'h00);
      wr(IRQ_FLAG_OFS, 8'hff);
      wr(IRQ_EN_OFS, en);
      rchk(LOW_PER_OFS, lp);
      rchk(HIGH_PER_OFS, hp);
      rchk(6'h2a, c1);
      rchk(IRQ_EN_OFS, en & IRQ_MASK);
      rchk(IRQ_FLAG_OFS, 8'h00);
      wr(CTRLA_OFS, 8'h01);
      repeat (100) @(posedge i_mclk);
      rd2(LOW_CNT_OFS);
      chk(d1, nxt(d0, lp));
      rd2(HIGH_CNT_OFS);
      chk(d1, nxt(d0, hp));
      op(1'b1, 1'b0, HIGH_CNT_OFS, v);
      rd2(HIGH_CNT_OFS);
      chk(d0, v);
      chk(d1, nxt(v, hp));
      wr(CTRLA_OFS, 8'h00);
      repeat (3) @(posedge i_mclk);
      rd2(LOW_CNT_OFS);
      chk(d1, d0);
      rchk(IRQ_FLAG_OFS, 8'h33);
      chk({7'h00, irq}, {7'h00, |(8'h33 & en)});
      wr(IRQ_FLAG_OFS, m);
      rchk(IRQ_FLAG_OFS, 8'h33 & ~m);
    end
    wr(CMD_CLR_OFS, 8'h0f);
    rchk(CMD_SET_OFS, 8'h00);
    wr(LOW_PER_OFS, 8'h05);
    wr(LOW_CNT_OFS, 8'h33);
    wr(CMD_SET_OFS, 8'h0d);
    rchk(CMD_CLR_OFS, 8'h01);
    rchk(LOW_CNT_OFS, 8'h33);
    wr(CMD_CLR_OFS, 8'h01);
    rchk(CMD_CLR_OFS, 8'h00);
    wr(CTRLA_OFS, 8'h01);
    wr(CMD_SET_OFS, 8'h0f);
    rchk(LOW_PER_OFS, 8'h05);
    wr(CTRLA_OFS, 8'h00);
    wr(CMD_SET_OFS, 8'h0c);
    rchk(LOW_PER_OFS, 8'hff);
    rchk(HIGH_PER_OFS, 8'hff);
    rchk(LOW_CNT_OFS, 8'h00);
    rchk(LCMP_BASE_OFS, 8'h00);
    rchk(CMD_SET_OFS, 8'h03);
    wr(LOW_CNT_OFS, 8'h22);
    wr(CMD_SET_OFS, 8'h04);
    rchk(LOW_CNT_OFS, 8'h22);
    wr(CMD_SET_OFS, 8'h08);
    rchk(LOW_CNT_OFS, 8'h00);
    wr(CMD_CLR_OFS, 8'h03);
    // Count is loaded first so that a wrongly taken restart would zero it
    wr(LOW_CNT_OFS, 8'h22);
    wr(CMD_SET_OFS, 8'h08);
    rchk(LOW_CNT_OFS, 8'h22);
    wr(CTRLA_OFS, 8'h01);
    halt <= 1'b1;
    repeat (5) @(posedge i_mclk);
    rd2(LOW_CNT_OFS);
    chk(d1, d0);
    chk({7'h00, running}, 8'h00);
    wr(DBG_OFS, 8'h01);
    repeat (4) @(posedge i_mclk);
    rd2(LOW_CNT_OFS);
    chk(d1, nxt(d0, 8'hff));
    // Clock enable low must freeze the count across several edges
    op(1'b0, 1'b1, LOW_CNT_OFS, 8'h00);
    @(posedge i_mclk);
    i_ce <= 1'b0;
    req <= '0;
    #1;
    d0 = rdata;
    repeat (5) @(posedge i_mclk);
    i_ce <= 1'b1;
    req <= '{1'b0, 1'b1, LOW_CNT_OFS, 8'h00};
    op(1'b0, 1'b0, 6'h00, 8'h00);
    #1;
    chk(rdata, nxt(d0, 8'hff));
    rchk(DBG_OFS, 8'h01);
    halt <= 1'b0;
    wr(SPLIT_CTRL_OFS, 8'h00);
    rchk(LOW_PER_OFS, 8'h00);
    // Second reset, with the timer stopped by split mode off, brings the periods back to all ones
    @(posedge i_mclk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rstn <= 1'b1;
    wr(SPLIT_CTRL_OFS, 8'h01);
    rchk(LOW_PER_OFS, 8'hff);
    rchk(HIGH_PER_OFS, 8'hff);
    summarize();
  end
endmodule

`default_nettype wire
